// *** pdc_pkg.sv ***
package pdc_pkg;

    // Register indices as printed; byte address is four times the index
    localparam logic [9:0] PDC_IDX_POWER_CONTROL = 10'h087;
    localparam logic [9:0] PDC_IDX_IO_CONTROL = 10'h0F8;
    localparam logic [9:0] PDC_IDX_TIMER_VALUE = 10'h100;
    localparam logic [9:0] PDC_IDX_MODE_STATUS = 10'h101;
    localparam logic [11:0] PDC_ADDR_POWER_CONTROL = 12'h21C;
    localparam logic [11:0] PDC_ADDR_IO_CONTROL = 12'h3E0;
    localparam logic [11:0] PDC_ADDR_TIMER_VALUE = 12'h400;
    localparam logic [11:0] PDC_ADDR_MODE_STATUS = 12'h404;

    // Power control fields
    localparam int PDC_PC_IDLE = 0;
    localparam int PDC_PC_SOFT_PD = 1;
    localparam int PDC_PC_RESUME = 5;
    localparam int PDC_PC_HARD_EN = 6;

    // I/O control fields
    localparam int PDC_IO_FLOAT = 0;
    localparam int PDC_IO_HIZ_P1 = 1;
    localparam int PDC_IO_WEAK_PU = 4;
    localparam int PDC_IO_RX_ERR = 5;
    localparam int PDC_IO_CHAIN = 6;
    localparam logic [7:0] PDC_IO_WR_MASK = 8'h5F;

    // Reset values
    localparam logic [7:0] PDC_RST_POWER_CONTROL = 8'h00;
    localparam logic [7:0] PDC_RST_IO_CONTROL = 8'h00;
    localparam logic [31:0] PDC_RST_TIMER = 32'h0000_0000;

    typedef enum logic [1:0] {
        PDC_RUN = 2'b00,
        PDC_IDLE = 2'b01,
        PDC_SOFT_PD = 2'b10,
        PDC_HARD_PD = 2'b11
    } pdc_mode_e;

    // Pin-level control handed to the port pad logic
    typedef struct packed {
        logic drive_one;
        logic float_out;
        logic [2:0] hiz_in;
        logic weak_pullup_only;
    } pdc_port_ctl_s;

    // Restart requests handed to the instruction sequencer
    typedef struct packed {
        logic restart_zero;
        logic to_vector;
        logic resume_next;
    } pdc_restart_s;

endpackage

// *** pdc_top.sv ***
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
// Summary of operation
// - Idle bit stops execution, oscillator keeps running
// - Soft power-down bit stops execution and oscillator
// - Enabled hard power-down entered on power-fail falling edge
// - Reset ends every mode, restart at zero
// - Interrupt ends idle/soft, vector or resume
// - Timers 0/1 count external ticks while stopped
// - I/O bit 0 floats ports in power-down
// - I/O bits 1-3 make ports high-impedance inputs
// - I/O bit 4 leaves only weak pull-up
// - Overrun or framing error sets receive error flag
// - I/O bit 6 chains timers into 32 bits
// - Reset drives all ports to one directly
// - Resume select bit 5, hard enable bit 6
module pdc_top
    import pdc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic port3_bit5,
    input wire logic ext_irq,
    input wire logic serial_irq,
    input wire logic timer0_ext_tick,
    input wire logic timer1_ext_tick,
    input wire logic rx_overrun,
    input wire logic rx_framing_err,
    output logic cpu_run_en,
    output logic osc_run,
    output pdc_mode_e power_mode,
    output pdc_restart_s restart,
    output pdc_port_ctl_s port_ctl
);

    pdc_mode_e mode_q, mode_d;
    logic [7:0] pwr_ctl_q, pwr_ctl_d;
    logic [7:0] io_ctl_q, io_ctl_d;
    logic [31:0] tmr_q, tmr_d;
    logic pf_prev_q;
    logic boot_q;
    pdc_restart_s rs_q, rs_d;
    logic rdy_q, rdy_d;
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d;
    logic acc, wr_en, mapped, tmr_wake, wake, pf_fall, stopped;
    logic [16:0] sum_lo, sum_hi;
    logic [32:0] sum_all;

    // Bus decode; one wait state keeps read data registered
    assign acc = psel && penable;
    assign wr_en = acc && pwrite && rdy_q;
    assign mapped = (paddr == PDC_ADDR_POWER_CONTROL) ||
                    (paddr == PDC_ADDR_IO_CONTROL) ||
                    (paddr == PDC_ADDR_TIMER_VALUE) ||
                    (paddr == PDC_ADDR_MODE_STATUS);
    assign pready = rdy_q;
    assign prdata = rdata_q;
    assign pslverr = err_q;

    always_comb begin
        rdy_d = acc && !rdy_q;
        rdata_d = rdata_q;
        err_d = 1'b0;
        if (acc && !rdy_q) begin
            err_d = !mapped;
            case (paddr)
                PDC_ADDR_POWER_CONTROL: rdata_d = {24'h000000, pwr_ctl_q};
                PDC_ADDR_IO_CONTROL: rdata_d = {24'h000000, io_ctl_q};
                PDC_ADDR_TIMER_VALUE: rdata_d = tmr_q;
                PDC_ADDR_MODE_STATUS: rdata_d = {30'h00000000, mode_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdy_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else begin
            rdy_q <= rdy_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    // External-tick timers; they run off their own ticks so a stopped
    // oscillator does not freeze them
    assign sum_lo = {1'b0, tmr_q[15:0]} + 17'h00001;
    assign sum_hi = {1'b0, tmr_q[31:16]} + 17'h00001;
    assign sum_all = {1'b0, tmr_q} + 33'h000000001;

    always_comb begin
        tmr_d = tmr_q;
        tmr_wake = 1'b0;
        if (io_ctl_q[PDC_IO_CHAIN]) begin
            if (timer0_ext_tick) begin
                tmr_d = sum_all[31:0];
                tmr_wake = sum_all[32];
            end
        end else begin
            if (timer0_ext_tick) begin
                tmr_d[15:0] = sum_lo[15:0];
                tmr_wake = sum_lo[16];
            end
            if (timer1_ext_tick) begin
                tmr_d[31:16] = sum_hi[15:0];
                tmr_wake = tmr_wake || sum_hi[16];
            end
        end
    end

    // Wake sources and power-fail edge
    assign wake = ext_irq || serial_irq || tmr_wake;
    assign pf_fall = pf_prev_q && !port3_bit5;
    assign stopped = (mode_q == PDC_SOFT_PD) || (mode_q == PDC_HARD_PD);

    // Mode sequencer; a write only arms the bit, entry follows the
    // completed write so the writing access finishes first
    always_comb begin
        mode_d = mode_q;
        pwr_ctl_d = pwr_ctl_q;
        rs_d = '0;
        if (wr_en && paddr == PDC_ADDR_POWER_CONTROL) begin
            pwr_ctl_d = pwdata[7:0];
        end
        case (mode_q)
            PDC_RUN: begin
                if (pwr_ctl_q[PDC_PC_HARD_EN] && pf_fall) begin
                    mode_d = PDC_HARD_PD;
                end else if (pwr_ctl_q[PDC_PC_SOFT_PD]) begin
                    mode_d = PDC_SOFT_PD;
                end else if (pwr_ctl_q[PDC_PC_IDLE]) begin
                    mode_d = PDC_IDLE;
                end
            end
            PDC_IDLE, PDC_SOFT_PD: begin
                if (pwr_ctl_q[PDC_PC_HARD_EN] && pf_fall) begin
                    mode_d = PDC_HARD_PD;
                end else if (wake) begin
                    mode_d = PDC_RUN;
                    pwr_ctl_d[PDC_PC_IDLE] = 1'b0;
                    pwr_ctl_d[PDC_PC_SOFT_PD] = 1'b0;
                    rs_d.resume_next = pwr_ctl_q[PDC_PC_RESUME];
                    rs_d.to_vector = !pwr_ctl_q[PDC_PC_RESUME];
                end
            end
            PDC_HARD_PD: begin
                mode_d = PDC_HARD_PD; // Only reset leaves it
            end
            default: mode_d = PDC_RUN;
        endcase
    end

    // Register update; reset ends every mode
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= PDC_RUN;
            pwr_ctl_q <= PDC_RST_POWER_CONTROL;
            rs_q <= '0;
            pf_prev_q <= 1'b1;
            boot_q <= 1'b1;
            tmr_q <= PDC_RST_TIMER;
        end else begin
            mode_q <= mode_d;
            pwr_ctl_q <= pwr_ctl_d;
            rs_q <= rs_d;
            pf_prev_q <= port3_bit5;
            boot_q <= 1'b0;
            tmr_q <= tmr_d;
        end
    end

    // I/O control; the error flag is sticky and a fresh error beats a clear
    always_comb begin
        io_ctl_d = io_ctl_q;
        if (wr_en && paddr == PDC_ADDR_IO_CONTROL) begin
            io_ctl_d = pwdata[7:0] & PDC_IO_WR_MASK;
        end
        if (rx_overrun || rx_framing_err) begin
            io_ctl_d[PDC_IO_RX_ERR] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            io_ctl_q <= PDC_RST_IO_CONTROL;
        end else begin
            io_ctl_q <= io_ctl_d;
        end
    end

    // Outputs; reset reaches all port controls except weak_pullup_only without waiting on the clock
    assign cpu_run_en = (mode_q == PDC_RUN) && !rst;
    assign osc_run = !stopped;
    assign power_mode = mode_q;
    assign restart.restart_zero = boot_q;
    assign restart.to_vector = rs_q.to_vector;
    assign restart.resume_next = rs_q.resume_next;
    assign port_ctl.drive_one = rst;
    assign port_ctl.float_out = io_ctl_q[PDC_IO_FLOAT] && stopped
                                && !rst;
    assign port_ctl.hiz_in = rst ? 3'h0 : io_ctl_q[PDC_IO_HIZ_P1 +: 3];
    assign port_ctl.weak_pullup_only = io_ctl_q[PDC_IO_WEAK_PU];

    a_idle_entry: assert property (@(posedge clk) disable iff (rst)
        (mode_q == PDC_RUN && pwr_ctl_q[PDC_PC_IDLE]
         && !pwr_ctl_q[PDC_PC_SOFT_PD]
         && !(pwr_ctl_q[PDC_PC_HARD_EN] && pf_fall))
        |=> (mode_q == PDC_IDLE && osc_run && !cpu_run_en))
        else $error("idle not entered");

    a_idle_osc: assert property (@(posedge clk) disable iff (rst)
        (mode_q == PDC_IDLE) |-> (osc_run && !cpu_run_en))
        else $error("idle mode clock or execution wrong");

    a_soft_entry: assert property (@(posedge clk) disable iff (rst)
        (mode_q == PDC_RUN && pwr_ctl_q[PDC_PC_SOFT_PD] && !pf_fall)
        |=> (mode_q == PDC_SOFT_PD && !osc_run))
        else $error("soft power-down not entered");

    a_hard_entry: assert property (@(posedge clk) disable iff (rst)
        (mode_q != PDC_HARD_PD && pwr_ctl_q[PDC_PC_HARD_EN]
         && $fell(port3_bit5) && !$past(rst))
        |=> mode_q == PDC_HARD_PD)
        else $error("hard power-down missed");

    a_hard_stopped: assert property (@(posedge clk) disable iff (rst)
        (mode_q == PDC_HARD_PD) |-> (!osc_run && !cpu_run_en))
        else $error("hard power-down left clock or execution on");

    a_hard_hold: assert property (@(posedge clk) disable iff (rst)
        (mode_q == PDC_HARD_PD) |=> (mode_q == PDC_HARD_PD))
        else $error("hard power-down left without reset");

    a_reset_restart: assert property (@(posedge clk)
        rst |=> (mode_q == PDC_RUN && restart.restart_zero))
        else $error("reset did not restart");

    a_wake_path: assert property (@(posedge clk) disable iff (rst)
        ((mode_q == PDC_IDLE || mode_q == PDC_SOFT_PD) && wake && !pf_fall)
        |=> (mode_q == PDC_RUN && !pwr_ctl_q[PDC_PC_IDLE]
             && restart.resume_next == $past(pwr_ctl_q[PDC_PC_RESUME])
             && restart.to_vector != restart.resume_next))
        else $error("wake path wrong");

    a_wake_pulse: assert property (@(posedge clk) disable iff (rst)
        (restart.to_vector || restart.resume_next)
        |=> !(restart.to_vector || restart.resume_next))
        else $error("restart request longer than one cycle");

    a_power_write: assert property (@(posedge clk) disable iff (rst)
        (psel && penable && pready && pwrite
         && paddr == PDC_ADDR_POWER_CONTROL)
        |=> (pwr_ctl_q[PDC_PC_RESUME] == $past(pwdata[PDC_PC_RESUME])
             && pwr_ctl_q[PDC_PC_HARD_EN] == $past(pwdata[PDC_PC_HARD_EN])))
        else $error("power control field not stored");

    a_rx_err_set: assert property (@(posedge clk) disable iff (rst)
        (rx_overrun || rx_framing_err) |=> io_ctl_q[PDC_IO_RX_ERR])
        else $error("receive error flag not set");

    a_err_sticky: assert property (@(posedge clk) disable iff (rst)
        (io_ctl_q[PDC_IO_RX_ERR]
         && !(wr_en && paddr == PDC_ADDR_IO_CONTROL))
        |=> io_ctl_q[PDC_IO_RX_ERR])
        else $error("receive error flag lost");

    a_chain_count: assert property (@(posedge clk) disable iff (rst)
        (io_ctl_q[PDC_IO_CHAIN] && timer0_ext_tick)
        |=> tmr_q == $past(tmr_q) + 32'h0000_0001)
        else $error("chained counter wrong");

    a_chain_hold: assert property (@(posedge clk) disable iff (rst)
        (io_ctl_q[PDC_IO_CHAIN] && !timer0_ext_tick) |=> $stable(tmr_q))
        else $error("chained counter moved without tick");

    a_split_count: assert property (@(posedge clk) disable iff (rst)
        (!io_ctl_q[PDC_IO_CHAIN] && timer0_ext_tick)
        |=> tmr_q[15:0] == $past(tmr_q[15:0]) + 16'h0001)
        else $error("timer 0 did not count its tick");

    a_port_reset: assert property (@(posedge clk) disable iff (1'b0)
        rst |-> (port_ctl.drive_one && !port_ctl.float_out))
        else $error("ports not forced high in reset");

    a_hiz_reset: assert property (@(posedge clk) disable iff (1'b0)
        rst |-> (port_ctl.hiz_in == 3'h0 && !cpu_run_en))
        else $error("ports not released to output in reset");

    a_port_float: assert property (@(posedge clk) disable iff (rst)
        port_ctl.float_out == (io_ctl_q[PDC_IO_FLOAT] && !osc_run))
        else $error("float control wrong");

endmodule

// *** pdc_pfail_model.sv ***
`timescale 1ns/1ps
// Power-fail detector and reset source on the far side of the device
module pdc_pfail_model (
    input wire logic clk,
    input wire logic fail_req,
    input wire logic reset_req,
    output logic port3_bit5,
    output logic rst
);
    // Start in reset with supply good
    initial begin
        port3_bit5 = 1'b1;
        rst = 1'b1;
    end
    // Detector line falls high to low on a supply failure
    always @(posedge clk) begin
        port3_bit5 <= ~fail_req;
        rst <= reset_req;
    end
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import pdc_pkg::*;
    logic clk = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, rst, port3_bit5, cpu_run_en, osc_run;
    logic fail_req = 1'b0, reset_req = 1'b1;
    logic ext_irq = 1'b0, serial_irq = 1'b0, t0 = 1'b0, t1 = 1'b0;
    logic rx_overrun = 1'b0, rx_framing_err = 1'b0;
    pdc_mode_e power_mode;
    pdc_restart_s restart;
    pdc_port_ctl_s port_ctl;
    int failures = 0, checks = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    pdc_pfail_model PFM (.clk(clk), .fail_req(fail_req),
        .reset_req(reset_req), .port3_bit5(port3_bit5), .rst(rst));

    pdc_top DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port3_bit5(port3_bit5),
        .ext_irq(ext_irq), .serial_irq(serial_irq), .timer0_ext_tick(t0),
        .timer1_ext_tick(t1), .rx_overrun(rx_overrun),
        .rx_framing_err(rx_framing_err), .cpu_run_en(cpu_run_en),
        .osc_run(osc_run), .power_mode(power_mode), .restart(restart),
        .port_ctl(port_ctl));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    // APB master; pready is taken at the rising edge, request held till then
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp,
        input logic e);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, er}, {31'h0, e});
    endtask

    // One-cycle pulses on error and tick inputs
    task automatic pulse(input logic [3:0] s);
        @(posedge clk);
        {rx_framing_err, rx_overrun, t1, t0} <= s;
        @(posedge clk);
        {rx_framing_err, rx_overrun, t1, t0} <= 4'h0;
    endtask

    task automatic wake(input logic ser, input logic resume);
        int n;
        n = 0;
        @(posedge clk);
        ext_irq <= ~ser;
        serial_irq <= ser;
        do begin
            @(negedge clk);
            n++;
        end while ((restart.to_vector | restart.resume_next) !== 1'b1
            && n < 10);
        chk({30'h0, restart.to_vector, restart.resume_next},
            {30'h0, ~resume, resume});
        chk({30'h0, power_mode}, {30'h0, PDC_RUN});
        @(posedge clk);
        ext_irq <= 1'b0;
        serial_irq <= 1'b0;
    endtask

    task automatic do_reset();
        int n;
        n = 0;
        @(posedge clk);
        reset_req <= 1'b1;
        repeat (3) @(negedge clk);
        chk({30'h0, port_ctl.drive_one, cpu_run_en}, 32'h2);
        @(posedge clk);
        reset_req <= 1'b0;
        do begin
            @(negedge clk);
            n++;
        end while (restart.restart_zero !== 1'b1 && n < 10);
        chk({31'h0, restart.restart_zero}, 32'h1);
        chk({30'h0, power_mode}, {30'h0, PDC_RUN});
    endtask

    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        do_reset();
        rchk(PDC_ADDR_POWER_CONTROL, 32'h0, 1'b0);
        rchk(PDC_ADDR_IO_CONTROL, 32'h0, 1'b0);
        rchk(PDC_ADDR_TIMER_VALUE, 32'h0, 1'b0);
        rchk(12'h010, 32'h0, 1'b1);
        $display("test reset done");
        apb(1'b1, PDC_ADDR_IO_CONTROL, 32'hFF);
        rchk(PDC_ADDR_IO_CONTROL, 32'h5F, 1'b0);
        chk({26'h0, port_ctl}, 32'h0F);
        pulse(4'h8);
        rchk(PDC_ADDR_IO_CONTROL, 32'h7F, 1'b0);
        apb(1'b1, PDC_ADDR_IO_CONTROL, 32'h01);
        pulse(4'h4);
        rchk(PDC_ADDR_IO_CONTROL, 32'h21, 1'b0);
        apb(1'b1, PDC_ADDR_IO_CONTROL, 32'h01);
        apb(1'b1, PDC_ADDR_POWER_CONTROL, 32'h60);
        rchk(PDC_ADDR_POWER_CONTROL, 32'h60, 1'b0);
        chk({30'h0, power_mode}, {30'h0, PDC_RUN});
        $display("test registers done");
        apb(1'b1, PDC_ADDR_POWER_CONTROL, 32'h01);
        repeat (2) @(negedge clk);
        chk({28'h0, power_mode, osc_run, cpu_run_en}, 32'h6);
        wake(1'b0, 1'b0);
        rchk(PDC_ADDR_POWER_CONTROL, 32'h0, 1'b0);
        $display("test idle done");
        apb(1'b1, PDC_ADDR_POWER_CONTROL, 32'h22);
        repeat (2) @(negedge clk);
        chk({28'h0, power_mode, osc_run, cpu_run_en}, 32'h8);
        chk({31'h0, port_ctl.float_out}, 32'h1);
        pulse(4'h1);
        pulse(4'h3);
        wake(1'b1, 1'b1);
        rchk(PDC_ADDR_POWER_CONTROL, 32'h20, 1'b0);
        rchk(PDC_ADDR_TIMER_VALUE, 32'h0001_0002, 1'b0);
        $display("test soft done");
        apb(1'b1, PDC_ADDR_POWER_CONTROL, 32'h40);
        fail_req <= 1'b1;
        repeat (4) @(negedge clk);
        chk({28'h0, power_mode, osc_run, cpu_run_en}, 32'hC);
        @(posedge clk);
        ext_irq <= 1'b1;
        repeat (5) @(negedge clk);
        chk({30'h0, power_mode}, {30'h0, PDC_HARD_PD});
        @(posedge clk);
        ext_irq <= 1'b0;
        fail_req <= 1'b0;
        do_reset();
        rchk(PDC_ADDR_POWER_CONTROL, 32'h0, 1'b0);
        $display("test hard done");
        apb(1'b1, PDC_ADDR_IO_CONTROL, 32'h40);
        pulse(4'h3);
        rchk(PDC_ADDR_TIMER_VALUE, 32'h0000_0001, 1'b0);
        rchk(PDC_ADDR_MODE_STATUS, 32'h0, 1'b0);
        $display("test chain done");
        wrap_up();
    end

    // Watchdog far beyond the fewer than two hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        wrap_up();
    end
endmodule
